// ==== verilog/swc_config_decode.sv ====
/*
  Supervisor and watchdog configuration decoder. Holds the two 16-bit
  configuration words behind an APB slave, samples them at device reset
  and drives static settings plus a few run-time enables.
  Assumes all inputs are synchronous to CLK_I and that DEV_RESET_I is a
  level held high for the whole device reset.
*/
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module swc_config_decode (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Register bus
  input wire swc_pkg::swc_apb_req_t APB_REQ_I,
  output swc_pkg::swc_apb_rsp_t APB_RSP_O,
  // Device reset and straps sampled with the words
  input wire logic DEV_RESET_I,
  input wire logic LOW_VOLT_PROG_EN_I,
  input wire logic LV_VARIANT_I,
  // Run-time qualifiers from the core and peripherals
  input wire logic SLEEP_I,
  input wire logic BROWNOUT_SW_ENABLE_I,
  input wire logic WDOG_SW_ENABLE_I,
  input wire logic ZERO_CROSS_SW_ENABLE_I,
  input wire logic ZERO_CROSS_MODULE_OFF_I,
  input wire logic STACK_FAULT_I,
  // Pin-routing lock requests
  input wire logic ROUTE_UNLOCK_I,
  input wire logic ROUTE_LOCK_SET_I,
  input wire logic ROUTE_LOCK_CLR_I,
  // Decoded results
  output swc_pkg::swc_settings_t SETTINGS_O,
  output swc_pkg::swc_runtime_t RUNTIME_O
);
  import swc_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] sup_word;
    logic [15:0] wdt_word;
    logic [15:0] sup_snap;
    logic [15:0] wdt_snap;
    logic load_pending;
    swc_settings_t settings;
    swc_runtime_t runtime;
    swc_route_t route;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swc_state_t;

  swc_state_t state_reg;
  swc_state_t state_next;
  logic bor_en;
  logic wdog_en;
  logic setup_phase;
  logic access_done;
  logic sample_now;

  // ==========================================================================
  // Word decoder
  // Pure function of the stored words and straps, so the snapshot is one register load
  function automatic swc_settings_t decode_words(
    input logic [15:0] sw,
    input logic [15:0] ww,
    input logic lvprog,
    input logic lv
  );
    swc_settings_t s;
    logic [1:0] lvl;
    logic [2:0] ccs;
    logic [2:0] cws;
    logic [4:0] cps;
    s = '0;
    lvl = sw[SUP_BOR_LVL_LSB +: 2];
    ccs = ww[WDT_CCS_LSB +: 3];
    cws = ww[WDT_CWS_LSB +: 3];
    cps = ww[WDT_CPS_LSB +: 5];
    s.ext_isa_en = ~sw[SUP_LEGACY_BIT];
    s.debugger_en = ~sw[SUP_DEBUG_BIT];
    s.stack_fault_rst_en = sw[SUP_STACK_BIT];
    s.pin_route_lock_once = sw[SUP_LOCK1_BIT];
    s.zero_cross_always_on = ~sw[SUP_ZC_OFF_BIT];
    // Top level code differs between the two supply variants
    case (lvl)
      2'b00: s.bor_level = SWC_BOR_2V85;
      2'b01: s.bor_level = SWC_BOR_2V70;
      2'b10: s.bor_level = SWC_BOR_2V45;
      2'b11: s.bor_level = lv ? SWC_BOR_1V90 : SWC_BOR_2V45;
      default: s.bor_level = SWC_BOR_2V85;
    endcase
    s.bor_mode = swc_mode_t'(sw[SUP_BOR_MODE_LSB +: 2]);
    s.low_power_bor_en = ~sw[SUP_LPBOR_BIT];
    s.powerup_timer_en = ~sw[SUP_PUT_OFF_BIT];
    s.ext_pin_is_reset = lvprog | sw[SUP_RSTPIN_BIT];
    s.wdog_mode = swc_mode_t'(ww[WDT_MODE_LSB +: 2]);
    // Clock source; reserved codes fall back to the low oscillator
    if (s.wdog_mode == SWC_MODE_OFF) begin
      s.wdog_clk = SWC_WCLK_NONE;
    end else begin
      case (ccs)
        CCS_LFO: s.wdog_clk = SWC_WCLK_LFO;
        CCS_MFO: s.wdog_clk = SWC_WCLK_MFO;
        CCS_SW: s.wdog_clk = SWC_WCLK_SW;
        default: s.wdog_clk = SWC_WCLK_LFO;
      endcase
    end
    // Open share in eighths: code 000 is one eighth, i.e. 12.5 percent
    if (cws == CWS_SW || cws == CWS_FULL) begin
      s.wdog_win_open_eighths = WIN_FULL_EIGHTHS;
    end else begin
      s.wdog_win_open_eighths = 4'(cws) + 4'h1;
    end
    s.wdog_win_sw_ctrl = (cws == CWS_SW);
    s.wdog_win_keyed = (cws != CWS_SW);
    // Period exponent; out-of-range codes fall back to the shortest
    if (cps == CPS_SW) begin
      s.wdog_period_exp = PERIOD_EXP_SW_DFLT;
      s.wdog_period_sw_ctrl = 1'b1;
    end else if (cps > CPS_MAX_FIXED) begin
      s.wdog_period_exp = PERIOD_EXP_MIN;
      s.wdog_period_sw_ctrl = 1'b0;
    end else begin
      s.wdog_period_exp = cps + PERIOD_EXP_OFFSET;
      s.wdog_period_sw_ctrl = 1'b0;
    end
    return s;
  endfunction : decode_words

  // ==========================================================================
  // Mode decoders for brown-out and watchdog enables
  swc_mode_decode u_bor_mode (
    .mode_i(state_reg.settings.bor_mode),
    .sw_enable_i(BROWNOUT_SW_ENABLE_I),
    .sleep_i(SLEEP_I),
    .enable_o(bor_en)
  );

  swc_mode_decode u_wdog_mode (
    .mode_i(state_reg.settings.wdog_mode),
    .sw_enable_i(WDOG_SW_ENABLE_I),
    .sleep_i(SLEEP_I),
    .enable_o(wdog_en)
  );

  // ==========================================================================
  // Bus phase decode
  assign setup_phase = APB_REQ_I.psel & ~APB_REQ_I.penable;
  assign access_done = APB_REQ_I.psel & APB_REQ_I.penable & state_reg.pready;
  // Snapshot once after power-up and on every device reset cycle
  assign sample_now = DEV_RESET_I | state_reg.load_pending;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;

    // Stored words; a write here only shows after the next device reset
    if (access_done && APB_REQ_I.pwrite && !state_reg.pslverr) begin
      if (APB_REQ_I.paddr == SUP_WORD_ADDR) begin
        state_next.sup_word = APB_REQ_I.pwdata[15:0] & SUP_WORD_MASK;
      end else if (APB_REQ_I.paddr == WDT_WORD_ADDR) begin
        state_next.wdt_word = APB_REQ_I.pwdata[15:0] & WDT_WORD_MASK;
      end
    end

    // Snapshot of words and straps; held constant between device resets
    state_next.load_pending = 1'b0;
    if (sample_now) begin
      state_next.sup_snap = state_reg.sup_word;
      state_next.wdt_snap = state_reg.wdt_word;
      state_next.settings = decode_words(state_reg.sup_word,
        state_reg.wdt_word, LOW_VOLT_PROG_EN_I, LV_VARIANT_I);
    end

    // Run-time enables, one register stage behind their inputs
    state_next.runtime.bor_active = bor_en;
    state_next.runtime.wdog_running = wdog_en;
    // Module-off bit only matters when the detector is not forced on
    state_next.runtime.zero_cross_on = state_reg.settings.zero_cross_always_on
      | (ZERO_CROSS_SW_ENABLE_I & ~ZERO_CROSS_MODULE_OFF_I);
    state_next.runtime.stack_fault_reset = STACK_FAULT_I
      & state_reg.settings.stack_fault_rst_en;

    // Pin-routing lock: an unlock in the closed state opens one change window
    case (state_reg.route)
      SWC_ROUTE_CLOSED: begin
        if (ROUTE_UNLOCK_I) begin
          state_next.route = SWC_ROUTE_OPEN;
        end
      end
      SWC_ROUTE_OPEN: begin
        if (ROUTE_LOCK_SET_I) begin
          state_next.runtime.pin_route_locked = 1'b1;
          // In lock-once mode the set is final until device reset
          state_next.route = state_reg.settings.pin_route_lock_once ?
            SWC_ROUTE_SEALED : SWC_ROUTE_CLOSED;
        end else if (ROUTE_LOCK_CLR_I) begin
          state_next.runtime.pin_route_locked = 1'b0;
          state_next.route = SWC_ROUTE_CLOSED;
        end
      end
      SWC_ROUTE_SEALED: begin
        state_next.route = SWC_ROUTE_SEALED;
      end
      default: begin
        state_next.route = SWC_ROUTE_CLOSED;
      end
    endcase
    if (DEV_RESET_I) begin
      state_next.route = SWC_ROUTE_CLOSED;
      state_next.runtime.pin_route_locked = 1'b0;
    end

    // Bus slave: answer in the first access cycle, no wait states
    state_next.pready = 1'b0;
    if (setup_phase && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h0;
      case (APB_REQ_I.paddr)
        SUP_WORD_ADDR: state_next.prdata = {16'h0, state_reg.sup_word};
        WDT_WORD_ADDR: state_next.prdata = {16'h0, state_reg.wdt_word};
        STATUS_ADDR: state_next.prdata = {state_reg.wdt_snap,
          state_reg.sup_snap};
        RUNTIME_ADDR: state_next.prdata = {25'h0, state_reg.route,
          state_reg.runtime};
        // Unmapped or misaligned addresses report an error
        default: state_next.pslverr = 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // State register; the words come back erased at power-on reset
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= '0;
      state_reg.sup_word <= SUP_WORD_RST;
      state_reg.wdt_word <= WDT_WORD_RST;
      state_reg.load_pending <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign APB_RSP_O.pready = state_reg.pready;
  assign APB_RSP_O.pslverr = state_reg.pslverr;
  assign APB_RSP_O.prdata = state_reg.prdata;
  assign SETTINGS_O = state_reg.settings;
  assign RUNTIME_O = state_reg.runtime;

endmodule : swc_config_decode

`default_nettype wire

// ==== verilog/swc_pkg.sv ====
/*
  Shared definitions of the supervisor and watchdog configuration decoder:
  register indices and byte addresses, field positions, erased values,
  write masks, mode encodings and the packed carriers of the top module.
  Assumes a 32-bit APB with a 24-bit byte address.
*/
package swc_pkg;

  // ==========================================================================
  // Register map (printed offsets are word indices, byte address = 4 x index)
  localparam logic [23:0] SUP_WORD_IDX = 24'h300002;
  localparam logic [23:0] WDT_WORD_IDX = 24'h300004;
  localparam logic [23:0] STATUS_IDX = 24'h300010;
  localparam logic [23:0] RUNTIME_IDX = 24'h300012;
  localparam logic [23:0] SUP_WORD_ADDR = {SUP_WORD_IDX[21:0], 2'b00};
  localparam logic [23:0] WDT_WORD_ADDR = {WDT_WORD_IDX[21:0], 2'b00};
  localparam logic [23:0] STATUS_ADDR = {STATUS_IDX[21:0], 2'b00};
  localparam logic [23:0] RUNTIME_ADDR = {RUNTIME_IDX[21:0], 2'b00};

  // ==========================================================================
  // Erased values and implemented-bit masks; unimplemented bits read zero
  localparam logic [15:0] SUP_WORD_RST = 16'hbf63;
  localparam logic [15:0] SUP_WORD_MASK = 16'hbfe3;
  localparam logic [15:0] WDT_WORD_RST = 16'h3f7f;
  localparam logic [15:0] WDT_WORD_MASK = 16'h3f7f;

  // ==========================================================================
  // Supervisor word field positions
  localparam int unsigned SUP_LEGACY_BIT = 15;
  localparam int unsigned SUP_DEBUG_BIT = 13;
  localparam int unsigned SUP_STACK_BIT = 12;
  localparam int unsigned SUP_LOCK1_BIT = 11;
  localparam int unsigned SUP_ZC_OFF_BIT = 10;
  localparam int unsigned SUP_BOR_LVL_LSB = 8;
  localparam int unsigned SUP_BOR_MODE_LSB = 6;
  localparam int unsigned SUP_LPBOR_BIT = 5;
  localparam int unsigned SUP_PUT_OFF_BIT = 1;
  localparam int unsigned SUP_RSTPIN_BIT = 0;

  // ==========================================================================
  // Watchdog word field positions and special codes
  localparam int unsigned WDT_CCS_LSB = 11;
  localparam int unsigned WDT_CWS_LSB = 8;
  localparam int unsigned WDT_MODE_LSB = 5;
  localparam int unsigned WDT_CPS_LSB = 0;
  localparam logic [2:0] CCS_LFO = 3'h0;
  localparam logic [2:0] CCS_MFO = 3'h1;
  localparam logic [2:0] CCS_SW = 3'h7;
  localparam logic [2:0] CWS_SW = 3'h7;
  localparam logic [2:0] CWS_FULL = 3'h6;
  localparam logic [3:0] WIN_FULL_EIGHTHS = 4'h8;
  localparam logic [4:0] CPS_MAX_FIXED = 5'h12;
  localparam logic [4:0] CPS_SW = 5'h1f;
  localparam logic [4:0] PERIOD_EXP_OFFSET = 5'h05;
  localparam logic [4:0] PERIOD_EXP_MIN = 5'h05;
  localparam logic [4:0] PERIOD_EXP_SW_DFLT = 5'h10;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    SWC_MODE_OFF = 2'b00,
    SWC_MODE_SW = 2'b01,
    SWC_MODE_AWAKE = 2'b10,
    SWC_MODE_ON = 2'b11
  } swc_mode_t;

  typedef enum logic [1:0] {
    SWC_BOR_2V85 = 2'b00,
    SWC_BOR_2V70 = 2'b01,
    SWC_BOR_2V45 = 2'b10,
    SWC_BOR_1V90 = 2'b11
  } swc_bor_level_t;

  typedef enum logic [1:0] {
    SWC_WCLK_NONE = 2'b00,
    SWC_WCLK_LFO = 2'b01,
    SWC_WCLK_MFO = 2'b10,
    SWC_WCLK_SW = 2'b11
  } swc_wclk_t;

  typedef enum logic [1:0] {
    SWC_ROUTE_CLOSED = 2'b00,
    SWC_ROUTE_OPEN = 2'b01,
    SWC_ROUTE_SEALED = 2'b10
  } swc_route_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [23:0] paddr;
    logic [31:0] pwdata;
  } swc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swc_apb_rsp_t;

  typedef struct packed {
    logic ext_isa_en;
    logic debugger_en;
    logic stack_fault_rst_en;
    logic pin_route_lock_once;
    logic zero_cross_always_on;
    swc_bor_level_t bor_level;
    swc_mode_t bor_mode;
    logic low_power_bor_en;
    logic powerup_timer_en;
    logic ext_pin_is_reset;
    swc_mode_t wdog_mode;
    swc_wclk_t wdog_clk;
    logic [3:0] wdog_win_open_eighths;
    logic wdog_win_sw_ctrl;
    logic wdog_win_keyed;
    logic [4:0] wdog_period_exp;
    logic wdog_period_sw_ctrl;
  } swc_settings_t;

  typedef struct packed {
    logic bor_active;
    logic wdog_running;
    logic zero_cross_on;
    logic stack_fault_reset;
    logic pin_route_locked;
  } swc_runtime_t;

endpackage : swc_pkg

// ==== verilog/swc_mode_decode.sv ====
/*
  Four-way enable decoder shared by the brown-out and watchdog paths:
  off, software controlled, on while awake, always on.
  Assumes its inputs are stable registered levels of one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module swc_mode_decode (
  // Mode and qualifiers
  input wire swc_pkg::swc_mode_t mode_i,
  input wire logic sw_enable_i,
  input wire logic sleep_i,
  // Result
  output logic enable_o
);
  import swc_pkg::*;

  // ==========================================================================
  // Decode; the software bit only counts in software mode
  always_comb begin
    case (mode_i)
      SWC_MODE_ON: enable_o = 1'b1;
      SWC_MODE_AWAKE: enable_o = ~sleep_i;
      SWC_MODE_SW: enable_o = sw_enable_i;
      SWC_MODE_OFF: enable_o = 1'b0;
      default: enable_o = 1'b0;
    endcase
  end

endmodule : swc_mode_decode

`default_nettype wire

// ==== dv/swc_config_decode_assertions.sv ====
/*
  Checker for the configuration decoder: held settings, field
  consistency, run-time enables and the routing lock policy.
  Assumes it is bound to swc_config_decode and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module swc_config_decode_assertions (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Qualifiers and requests
  input wire logic DEV_RESET_I,
  input wire logic SLEEP_I,
  input wire logic BROWNOUT_SW_ENABLE_I,
  input wire logic WDOG_SW_ENABLE_I,
  input wire logic ZERO_CROSS_SW_ENABLE_I,
  input wire logic ZERO_CROSS_MODULE_OFF_I,
  input wire logic STACK_FAULT_I,
  input wire logic ROUTE_UNLOCK_I,
  input wire logic ROUTE_LOCK_SET_I,
  input wire logic ROUTE_LOCK_CLR_I,
  // Decoded results
  input wire swc_pkg::swc_settings_t SETTINGS_O,
  input wire swc_pkg::swc_runtime_t RUNTIME_O
);
  import swc_pkg::*;

  // ==========================================================================
  // Helpers
  // Independent four-way enable decode, kept apart from the design's
  function automatic logic en(swc_mode_t m, logic sw, logic slp);
    return m == SWC_MODE_ON || (m == SWC_MODE_AWAKE && !slp) ||
      (m == SWC_MODE_SW && sw);
  endfunction : en

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Unlock followed by a request; only the reusable policy is predictable
  sequence s_unlock;
    !DEV_RESET_I && ROUTE_UNLOCK_I && !SETTINGS_O.pin_route_lock_once;
  endsequence
  sequence s_set;
    s_unlock ##1 (ROUTE_LOCK_SET_I && !DEV_RESET_I);
  endsequence
  sequence s_clr;
    s_unlock ##1 (ROUTE_LOCK_CLR_I && !ROUTE_LOCK_SET_I && !DEV_RESET_I);
  endsequence

  // ==========================================================================
  // Properties
  // Runtime checks skip the first edge after reset, while settings load
  property p_hold;
    !DEV_RESET_I && $past(RSTN_I) |=> $stable(SETTINGS_O);
  endproperty
  property p_stack;
    $past(RSTN_I) |=> RUNTIME_O.stack_fault_reset ==
      $past(STACK_FAULT_I && SETTINGS_O.stack_fault_rst_en);
  endproperty
  property p_bor;
    $past(RSTN_I) |=> RUNTIME_O.bor_active == $past(en(SETTINGS_O.bor_mode,
      BROWNOUT_SW_ENABLE_I, SLEEP_I));
  endproperty
  property p_wdog;
    $past(RSTN_I) |=> RUNTIME_O.wdog_running == $past(en(
      SETTINGS_O.wdog_mode, WDOG_SW_ENABLE_I, SLEEP_I));
  endproperty
  property p_zc;
    $past(RSTN_I) |=> RUNTIME_O.zero_cross_on ==
      $past(SETTINGS_O.zero_cross_always_on ||
      (ZERO_CROSS_SW_ENABLE_I && !ZERO_CROSS_MODULE_OFF_I));
  endproperty
  property p_sealed;
    RUNTIME_O.pin_route_locked && SETTINGS_O.pin_route_lock_once &&
      !DEV_RESET_I |=> RUNTIME_O.pin_route_locked;
  endproperty
  property p_free_set;
    s_set |=> RUNTIME_O.pin_route_locked;
  endproperty
  property p_free_clr;
    s_clr |=> !RUNTIME_O.pin_route_locked;
  endproperty
  property p_wclk;
    SETTINGS_O.wdog_mode == SWC_MODE_OFF |-> SETTINGS_O.wdog_clk ==
      SWC_WCLK_NONE;
  endproperty
  property p_win;
    SETTINGS_O.wdog_win_sw_ctrl |-> !SETTINGS_O.wdog_win_keyed &&
      SETTINGS_O.wdog_win_open_eighths == 4'h8;
  endproperty
  property p_period;
    SETTINGS_O.wdog_period_sw_ctrl |-> SETTINGS_O.wdog_period_exp == 5'h10;
  endproperty

  // ==========================================================================
  // Assertions
  a_hold: assert property (p_hold) else $error("settings moved");
  a_stack: assert property (p_stack) else $error("stack reset bad");
  a_bor: assert property (p_bor) else $error("brownout enable bad");
  a_wdog: assert property (p_wdog) else $error("watchdog enable bad");
  a_zc: assert property (p_zc) else $error("zero cross enable bad");
  a_sealed: assert property (p_sealed) else $error("lock released");
  a_free_set: assert property (p_free_set) else $error("no lock");
  a_free_clr: assert property (p_free_clr) else $error("no unlock");
  a_wclk: assert property (p_wclk) else $error("clock select bad");
  a_win: assert property (p_win) else $error("window bad");
  a_period: assert property (p_period) else $error("period bad");
endmodule : swc_config_decode_assertions

bind swc_config_decode swc_config_decode_assertions chk_u (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .DEV_RESET_I(DEV_RESET_I),
  .SLEEP_I(SLEEP_I), .BROWNOUT_SW_ENABLE_I(BROWNOUT_SW_ENABLE_I),
  .WDOG_SW_ENABLE_I(WDOG_SW_ENABLE_I),
  .ZERO_CROSS_SW_ENABLE_I(ZERO_CROSS_SW_ENABLE_I),
  .ZERO_CROSS_MODULE_OFF_I(ZERO_CROSS_MODULE_OFF_I),
  .STACK_FAULT_I(STACK_FAULT_I), .ROUTE_UNLOCK_I(ROUTE_UNLOCK_I),
  .ROUTE_LOCK_SET_I(ROUTE_LOCK_SET_I), .ROUTE_LOCK_CLR_I(ROUTE_LOCK_CLR_I),
  .SETTINGS_O(SETTINGS_O), .RUNTIME_O(RUNTIME_O)
);

`default_nettype wire

// ==== dv/swc_config_decode_tb.sv ====
/*
  Self-checking bench of the configuration decoder: word table, reset
  values, bus error, run-time enables and routing lock.
  Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/1ns
`default_nettype none

module swc_config_decode_tb;
  import swc_pkg::*;

  // ==========================================================================
  // Signals and design
  logic clk, rstn, dev, lvprog, lv, slp, bsw, wsw, zsw, zoff, sf;
  logic unl, lset, lclr, er;
  logic [31:0] rd;
  swc_apb_req_t req;
  swc_apb_rsp_t rsp;
  swc_settings_t st, exp_q;
  swc_runtime_t rt_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  // Rows: supervisor word, watchdog word, low-voltage programming, variant
  logic [33:0] rows [8] = '{
    {16'h0000, 16'h0000, 1'b0, 1'b0}, {16'hbfe3, 16'h3f7f, 1'b1, 1'b1},
    {16'h2d41, 16'h0932, 1'b0, 1'b0}, {16'h1280, 16'h1253, 1'b1, 1'b0},
    {16'h0300, 16'h1b1e, 1'b0, 1'b0}, {16'h8020, 16'h246b, 1'b0, 1'b1},
    {16'h0002, 16'h2d21, 1'b0, 1'b0}, {16'h04c0, 16'h3650, 1'b0, 1'b1}};

  swc_config_decode dut_u (.CLK_I(clk), .RSTN_I(rstn), .APB_REQ_I(req),
    .APB_RSP_O(rsp), .DEV_RESET_I(dev), .LOW_VOLT_PROG_EN_I(lvprog),
    .LV_VARIANT_I(lv), .SLEEP_I(slp), .BROWNOUT_SW_ENABLE_I(bsw),
    .WDOG_SW_ENABLE_I(wsw), .ZERO_CROSS_SW_ENABLE_I(zsw),
    .ZERO_CROSS_MODULE_OFF_I(zoff), .STACK_FAULT_I(sf),
    .ROUTE_UNLOCK_I(unl), .ROUTE_LOCK_SET_I(lset), .ROUTE_LOCK_CLR_I(lclr),
    .SETTINGS_O(st), .RUNTIME_O(rt_o));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // ==========================================================================
  // Tasks
  function automatic swc_settings_t exp_dec(logic [15:0] s, logic [15:0] w,
                                            logic p, logic v);
    swc_settings_t e;
    logic [2:0] c;
    logic [2:0] ws;
    logic [4:0] pc;
    c = w[13:11];
    ws = w[10:8];
    pc = w[4:0];
    e.ext_isa_en = ~s[15];
    e.debugger_en = ~s[13];
    e.stack_fault_rst_en = s[12];
    e.pin_route_lock_once = s[11];
    e.zero_cross_always_on = ~s[10];
    e.bor_level = swc_bor_level_t'((s[9:8] == 2'b11 && !v) ? 2'b10 :
      s[9:8]);
    e.bor_mode = swc_mode_t'(s[7:6]);
    e.low_power_bor_en = ~s[5];
    e.powerup_timer_en = ~s[1];
    e.ext_pin_is_reset = p | s[0];
    e.wdog_mode = swc_mode_t'(w[6:5]);
    e.wdog_clk = w[6:5] == 2'b00 ? SWC_WCLK_NONE : c == 3'h1 ? SWC_WCLK_MFO :
      c == 3'h7 ? SWC_WCLK_SW : SWC_WCLK_LFO;
    e.wdog_win_open_eighths = ws >= 3'h6 ? 4'h8 : {1'b0, ws} + 4'h1;
    e.wdog_win_sw_ctrl = ws == 3'h7;
    e.wdog_win_keyed = ws != 3'h7;
    e.wdog_period_exp = pc <= 5'h12 ? pc + 5'h05 :
      pc == 5'h1f ? 5'h10 : 5'h05;
    e.wdog_period_sw_ctrl = pc == 5'h1f;
    return e;
  endfunction : exp_dec

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // One transfer; entered right after a rising edge, ends after another
  task automatic apb(input logic w, input logic [23:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, {16'ha5a5, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) error_cnt++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  // Load words, confirm nothing moves, then sample them by device reset
  task automatic cfg(input logic [33:0] r);
    apb(1'b1, SUP_WORD_ADDR, r[33:18]);
    apb(1'b1, WDT_WORD_ADDR, r[17:2]);
    apb(1'b0, SUP_WORD_ADDR, 16'h0);
    chk(rd, {16'h0, r[33:18] & SUP_WORD_MASK});
    apb(1'b0, WDT_WORD_ADDR, 16'h0);
    chk(rd, {16'h0, r[17:2] & WDT_WORD_MASK});
    chk({4'h0, st}, {4'h0, exp_q});
    lvprog <= r[1];
    lv <= r[0];
    dev <= 1'b1;
    @(posedge clk);
    dev <= 1'b0;
    exp_q = exp_dec(r[33:18], r[17:2], r[1], r[0]);
    @(negedge clk);
    chk({4'h0, st}, {4'h0, exp_q});
    chk({16'h0, st[15:0]}, {16'h0, exp_q[15:0]});
    @(posedge clk);
    // Snapshot of the raw words taken at that same device reset
    apb(1'b0, STATUS_ADDR, 16'h0);
    chk(rd, {r[17:2] & WDT_WORD_MASK, r[33:18] & SUP_WORD_MASK});
  endtask : cfg

  task automatic rt(input logic [4:0] e);
    @(negedge clk);
    chk({27'h0, rt_o}, {27'h0, e});
    @(posedge clk);
  endtask : rt

  task automatic do_reset(input logic p);
    rstn <= 1'b0;
    lvprog <= p;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({4'h0, st}, 32'h0);
    @(negedge clk);
    exp_q = exp_dec(16'hbf63, 16'h3f7f, p, 1'b0);
    chk({4'h0, st}, {4'h0, exp_q});
    @(posedge clk);
    apb(1'b0, SUP_WORD_ADDR, 16'h0);
    chk(rd, 32'h0000bf63);
    apb(1'b0, WDT_WORD_ADDR, 16'h0);
    chk(rd, 32'h00003f7f);
    $display("test reset done");
  endtask : do_reset

  // ==========================================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    {dev, lvprog, lv, slp, bsw, wsw, zsw, zoff, sf, unl, lset, lclr} = '0;
    do_reset(1'b0);
    apb(1'b0, 24'h000004, 16'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      slp <= i[0];
      bsw <= i[1];
      wsw <= i[2];
      cfg(rows[i]);
    end
    $display("test table done");
    // Awake-only modes, one-way lock, stack reset enabled
    cfg({16'h1c80, 16'h0040, 1'b0, 1'b0});
    {zsw, zoff} <= 2'b00;
    @(posedge clk);
    rt(5'b00000);
    slp <= 1'b0;
    zsw <= 1'b1;
    sf <= 1'b1;
    unl <= 1'b1;
    @(posedge clk);
    {sf, unl, lset} <= 3'b001;
    rt(5'b11110);
    {unl, lset} <= 2'b10;
    @(posedge clk);
    {unl, lclr} <= 2'b01;
    rt(5'b11101);
    {lclr, zoff} <= 2'b01;
    @(posedge clk);
    rt(5'b11001);
    $display("test one-way lock done");
    // Software modes, reusable lock, zero cross forced on
    cfg({16'h0040, 16'h0020, 1'b0, 1'b0});
    {bsw, wsw, zsw, unl} <= 4'b1001;
    @(posedge clk);
    {unl, lset} <= 2'b01;
    rt(5'b10100);
    {unl, lset} <= 2'b10;
    @(posedge clk);
    {unl, lclr} <= 2'b01;
    rt(5'b10101);
    {lclr, lset, sf, bsw, wsw} <= 5'b01101;
    @(posedge clk);
    {lset, sf} <= 2'b00;
    rt(5'b01100);
    $display("test reusable lock done");
    do_reset(1'b1);
    summarize();
  end
endmodule : swc_config_decode_tb

`default_nettype wire
